// ===== include/sio_pkg.sv
// Purpose: shared constants and carriers for the clocked serial port
// Assumes: 32-bit classic Wishbone register access, 40 MHz mclk
// Notes:   all registers use the low byte only; upper bits read zero
package sio_pkg;
	localparam int        ADDR_W       = 5;
	localparam logic [4:0] CTRL_ADDR   = 5'h00;
	localparam logic [4:0] STAT_ADDR   = 5'h04;
	localparam logic [4:0] TXBUF_ADDR  = 5'h08;
	localparam logic [4:0] RXBUF_ADDR  = 5'h0c;

	localparam logic [1:0] MODE_RX     = 2'h1;
	localparam logic [1:0] MODE_TXRX   = 2'h2;

	localparam int        BYTE_BITS    = 8;
	localparam logic [3:0] LAST_BIT    = 4'h7;
	localparam logic [3:0] ALL_BITS    = 4'h8;

	localparam int        MCLK_NS      = 25;
	localparam int        SCLK_HALF_NS = 500;
	// half period of the generated serial clock, least time rounded up
	localparam int        HALF_CYCLES  = (SCLK_HALF_NS + MCLK_NS - 1) / MCLK_NS;

	typedef struct packed {
		logic [1:0] spare;
		logic       extClk;
		logic       msbFirst;
		logic [1:0] mode;
		logic       forceStop;
		logic       start;
	} ctrl_type;

	typedef struct packed {
		logic [1:0] spare;
		logic       rxOver;
		logic       txUnder;
		logic       rxFull;
		logic       txEmpty;
		logic       shiftActive;
		logic       busy;
	} status_type;

	localparam ctrl_type   CTRL_RESET  = 8'h00;
	localparam status_type STAT_RESET  = 8'h04;
	localparam logic [7:0] BUF_RESET   = 8'h00;
endpackage

// ===== logic/sync_two.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are asynchronous levels
// Notes:   first stage feeds the second stage only
module sync_two #(
	parameter int WIDTH = 2
) (
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			meta <= '1;
			q    <= '1;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// ===== logic/bit_shifter.sv
// Purpose: shared transmit/receive shift register
// Assumes: load and shift never coincide
// Notes:   shifted shows the value after the next shift, for capture
module bit_shifter #(
	parameter int WIDTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic             clear,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] loadData,
	input  wire logic             shift,
	input  wire logic             msbFirst,
	input  wire logic             inBit,
	output logic      [WIDTH-1:0] q,
	output logic      [WIDTH-1:0] shifted,
	output logic                  outBit
);
	if (WIDTH < 2)
	begin : g_check
		$error("bit_shifter needs at least two bits");
	end

	assign shifted = msbFirst ? {q[WIDTH-2:0], inBit} : {inBit, q[WIDTH-1:1]};
	assign outBit  = msbFirst ? q[WIDTH-1] : q[0];

	always_ff @(posedge mclk)
	begin
		if (reset || clear)
			q <= '0;
		else if (load)
			q <= loadData;
		else if (shift)
			q <= shifted;
	end
endmodule

// ===== logic/sync_serial_txrx.sv
// Purpose: 8-bit clocked serial port, full-duplex stop and error handling
// Assumes: classic Wishbone slave, one answer per request, mclk 40 MHz
// Notes:   serial clock is made here or sampled from the pin
//
// Notes on behaviour
// - clearing start finishes the current byte, drops busy, holds data out high.
// - force-stop halts at once and resets start, status and both buffers.
// - external clock byte begins without new transmit data: underrun flag sets.
// - first byte after start with no transmit data loaded also sets underrun.
// - after underrun the request still comes only when 8 bits arrived.
// - underrun flag set keeps serial data out high.
// - external clock byte finishing while receive full sets the overrun flag.
// - while overrun, new bits are dropped; receive buffer and shifter kept.
// - after overrun, first read gives buffer, second read gives shifter.
// - clearing overrun after reading also clears receive full.
// - after start clears, reception ends with the current byte; then busy low.
// - while overrun stays, no further interrupt requests.
// - mode 10 is full duplex, mode 01 receive only.
// - shift out on falling, sample on rising, in the chosen bit order.
// - shift active from first to eighth falling edge of each byte.
// - transmit write clears empty, receive read clears full, byte sets full.
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
module sync_serial_txrx #(
	parameter int HALF_CYCLES = sio_pkg::HALF_CYCLES
) (
	input  wire logic                      mclk,
	input  wire logic                      reset,
	input  wire logic                      cyc_i,
	input  wire logic                      stb_i,
	input  wire logic                      we_i,
	input  wire logic [sio_pkg::ADDR_W-1:0] adr_i,
	input  wire logic [3:0]                sel_i,
	input  wire logic [31:0]               dat_i,
	output logic      [31:0]               dat_o,
	output logic                           ack_o,
	input  wire logic                      sclkIn,
	output logic                           sclkOut,
	output logic                           sclkOe_n,
	input  wire logic                      sdiIn,
	output logic                           sdo,
	output logic                           serialIrqRequest
);
	if (HALF_CYCLES < 3 || HALF_CYCLES > 65535)
	begin : g_check
		$error("HALF_CYCLES must cover the two sync stages of data in");
	end

	sio_pkg::ctrl_type   ctrl;
	sio_pkg::status_type stat;
	logic [7:0]  txBuf;
	logic [7:0]  rxBuf;
	logic [7:0]  shq;
	logic [7:0]  shNext;
	logic        shOut;
	logic        busy;
	logic        shiftActive;
	logic        txEmpty;
	logic        rxFull;
	logic        txUnder;
	logic        rxOver;
	logic        rxReadOnce;
	logic [3:0]  fallCnt;
	logic [3:0]  bitCnt;
	logic [15:0] halfCnt;
	logic [1:0]  pinSync;
	logic        sclkLast;

	// bus decode
	logic wbReq;
	logic wbWrite;
	logic ctrlWrite;
	logic txWrite;
	logic rxRead;
	logic forceNow;
	assign wbReq     = cyc_i && stb_i && !ack_o;
	assign wbWrite   = wbReq && we_i && sel_i[0];
	assign ctrlWrite = wbWrite && adr_i == sio_pkg::CTRL_ADDR;
	assign txWrite   = wbWrite && adr_i == sio_pkg::TXBUF_ADDR;
	assign rxRead    = wbReq && !we_i && adr_i == sio_pkg::RXBUF_ADDR;
	assign forceNow  = ctrlWrite && dat_i[1];

	// link side: pin sampling and edge finding
	sync_two #(
		.WIDTH(2)
	) u_sync (
		.mclk (mclk),
		.reset(reset),
		.d    ({sclkIn, sdiIn}),
		.q    (pinSync)
	);

	always_ff @(posedge mclk)
	begin
		if (reset)
			sclkLast <= 1'b1;
		else
			sclkLast <= pinSync[1];
	end

	logic active;
	logic fullDuplex;
	logic inByte;
	logic genRun;
	logic genTick;
	logic fallEv;
	logic riseEv;
	assign fullDuplex = ctrl.mode == sio_pkg::MODE_TXRX;
	assign active     = fullDuplex || ctrl.mode == sio_pkg::MODE_RX;
	assign inByte     = fallCnt != 4'h0;
	// automatic wait: the generated clock pauses high between bytes
	assign genRun  = !ctrl.extClk && active
		&& (inByte || (ctrl.start && !rxFull && !(fullDuplex && txEmpty)));
	assign genTick = genRun && halfCnt == 16'(HALF_CYCLES - 1);
	// edges of the pin are taken only after both sync stages
	assign fallEv  = ctrl.extClk ? (sclkLast && !pinSync[1]) : (genTick && sclkOut);
	assign riseEv  = ctrl.extClk ? (!sclkLast && pinSync[1]) : (genTick && !sclkOut);

	always_ff @(posedge mclk)
	begin
		if (reset || forceNow || !genRun || genTick)
			halfCnt <= 16'h0000;
		else
			halfCnt <= halfCnt + 16'h0001;
	end
	always_ff @(posedge mclk)
	begin
		if (reset || forceNow)
			sclkOut <= 1'b1;
		else if (genTick)
			sclkOut <= !sclkOut;
		else if (!genRun && !inByte)
			sclkOut <= 1'b1;
	end
	always_ff @(posedge mclk)
	begin
		if (reset)
			sclkOe_n <= 1'b1;
		else
			sclkOe_n <= !((!ctrl.extClk) && active);
	end

	// byte sequencing
	logic startByte;
	logic midFall;
	logic riseIn;
	logic byteDone;
	logic underrunNow;
	logic overrunNow;
	assign startByte   = fallEv && !inByte && ctrl.start && active;
	assign midFall     = fallEv && inByte && fallCnt < sio_pkg::ALL_BITS;
	assign riseIn      = riseEv && inByte && bitCnt < fallCnt;
	assign byteDone    = riseIn && bitCnt == sio_pkg::LAST_BIT;
	// in full duplex the internal clock never starts a byte with nothing to send
	assign underrunNow = startByte && fullDuplex && txEmpty && ctrl.extClk;
	assign overrunNow  = byteDone && rxFull && !rxRead && !rxOver && ctrl.extClk;

	bit_shifter #(
		.WIDTH(sio_pkg::BYTE_BITS)
	) u_shift (
		.mclk    (mclk),
		.reset   (reset),
		.clear   (forceNow),
		.load    (startByte && !rxOver),
		.loadData(txBuf),
		.shift   (riseIn && !rxOver),
		.msbFirst(ctrl.msbFirst),
		.inBit   (pinSync[0]),
		.q       (shq),
		.shifted (shNext),
		.outBit  (shOut)
	);

	always_ff @(posedge mclk)
	begin
		if (reset || forceNow)
		begin
			fallCnt     <= 4'h0;
			bitCnt      <= 4'h0;
			shiftActive <= 1'b0;
		end
		else if (startByte)
		begin
			fallCnt     <= 4'h1;
			bitCnt      <= 4'h0;
			shiftActive <= 1'b1;
		end
		else
		begin
			if (midFall)
			begin
				fallCnt <= fallCnt + 4'h1;
				if (fallCnt == sio_pkg::LAST_BIT)
					shiftActive <= 1'b0;
			end
			if (byteDone)
			begin
				fallCnt <= 4'h0;
				bitCnt  <= 4'h0;
			end
			else if (riseIn)
				bitCnt <= bitCnt + 4'h1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset || forceNow)
			busy <= 1'b0;
		else if (startByte)
			busy <= 1'b1;
		else if ((byteDone || !inByte) && !ctrl.start)
			busy <= 1'b0;
	end

	// first bit goes out with the load, the rest on later falling edges
	always_ff @(posedge mclk)
	begin
		if (reset || forceNow)
			sdo <= 1'b1;
		else if (startByte)
			sdo <= !fullDuplex || txEmpty || txUnder
				|| (ctrl.msbFirst ? txBuf[7] : txBuf[0]);
		else if (midFall)
			sdo <= !fullDuplex || txUnder || shOut;
		else if ((byteDone || !inByte) && !ctrl.start)
			sdo <= 1'b1;
	end

	// status flags; a hardware set wins over a clear in the same cycle
	always_ff @(posedge mclk)
	begin
		if (reset || forceNow)
			txEmpty <= 1'b1;
		else if (startByte && fullDuplex)
			txEmpty <= 1'b1;
		else if (txWrite)
			txEmpty <= 1'b0;
	end
	always_ff @(posedge mclk)
	begin
		if (reset || forceNow)
			txUnder <= 1'b0;
		else if (underrunNow)
			txUnder <= 1'b1;
	end
	always_ff @(posedge mclk)
	begin
		if (reset || forceNow)
			rxOver <= 1'b0;
		else if (overrunNow)
			rxOver <= 1'b1;
		else if (rxRead && rxReadOnce)
			rxOver <= 1'b0;
	end
	always_ff @(posedge mclk)
	begin
		if (reset || forceNow)
			rxReadOnce <= 1'b0;
		else if (rxRead && rxOver)
			rxReadOnce <= !rxReadOnce;
	end
	always_ff @(posedge mclk)
	begin
		if (reset || forceNow)
			rxFull <= 1'b0;
		else if (byteDone && !rxOver && !overrunNow)
			rxFull <= 1'b1;
		else if (rxRead && (!rxOver || rxReadOnce))
			rxFull <= 1'b0;
	end
	always_ff @(posedge mclk)
	begin
		if (reset || forceNow)
			serialIrqRequest <= 1'b0;
		else
			serialIrqRequest <= byteDone && !rxOver && !overrunNow;
	end

	// buffers
	always_ff @(posedge mclk)
	begin
		if (reset || forceNow)
			rxBuf <= sio_pkg::BUF_RESET;
		else if (byteDone && !rxOver && !overrunNow)
			rxBuf <= shNext;
	end
	always_ff @(posedge mclk)
	begin
		if (reset || forceNow)
			txBuf <= sio_pkg::BUF_RESET;
		else if (txWrite)
			txBuf <= dat_i[7:0];
	end
	always_ff @(posedge mclk)
	begin
		if (reset)
			ctrl <= sio_pkg::CTRL_RESET;
		else if (ctrlWrite)
		begin
			ctrl          <= dat_i[7:0];
			ctrl.spare    <= 2'h0;
			ctrl.forceStop <= 1'b0;
			// force-stop clears only start; mode and clocking stay as written
			if (forceNow)
				ctrl.start <= 1'b0;
		end
	end

	assign stat = '{spare: 2'h0, rxOver: rxOver, txUnder: txUnder, rxFull: rxFull,
		txEmpty: txEmpty, shiftActive: shiftActive, busy: busy};

	// bus answer: one wait state, ack for one cycle, unmapped reads as zero
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end
		else
		begin
			ack_o <= wbReq;
			dat_o <= 32'h00000000;
			if (wbReq && !we_i)
			begin
				case (adr_i)
					sio_pkg::CTRL_ADDR:  dat_o[7:0] <= ctrl;
					sio_pkg::STAT_ADDR:  dat_o[7:0] <= stat;
					sio_pkg::TXBUF_ADDR: dat_o[7:0] <= txBuf;
					sio_pkg::RXBUF_ADDR: dat_o[7:0] <= (rxOver && rxReadOnce) ? shq : rxBuf;
					default:             dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	idle_high_a: assert property (@(posedge mclk) disable iff (reset)
		$fell(busy) |-> sdo)
		else $error("data out not high after stop");
	force_init_a: assert property (@(posedge mclk) disable iff (reset)
		forceNow |=> (!ctrl.start && stat == sio_pkg::STAT_RESET
			&& rxBuf == 8'h00 && txBuf == 8'h00 && !busy))
		else $error("force-stop left state behind");
	under_start_a: assert property (@(posedge mclk) disable iff (reset)
		(startByte && fullDuplex && txEmpty && ctrl.extClk) |=> txUnder && shiftActive)
		else $error("underrun not raised at shift start");
	under_high_a: assert property (@(posedge mclk) disable iff (reset)
		txUnder && $past(txUnder) |-> sdo)
		else $error("data out moved during underrun");
	irq_full_a: assert property (@(posedge mclk) disable iff (reset)
		serialIrqRequest |-> rxFull && bitCnt == 4'h0 && !rxOver)
		else $error("request without a whole byte");
	over_quiet_a: assert property (@(posedge mclk) disable iff (reset)
		rxOver |-> !serialIrqRequest)
		else $error("request during overrun");
	over_keep_a: assert property (@(posedge mclk) disable iff (reset)
		rxOver && $past(rxOver) && !$past(forceNow) |-> $stable(rxBuf) && $stable(shq))
		else $error("data changed during overrun");
	over_clear_a: assert property (@(posedge mclk) disable iff (reset)
		$fell(rxOver) && !$past(forceNow) |-> !rxFull)
		else $error("receive full left after overrun clear");
	active_span_a: assert property (@(posedge mclk) disable iff (reset)
		shiftActive |-> busy && fallCnt != 4'h0 && fallCnt < 4'h8)
		else $error("shift active outside a byte");
endmodule

// ===== sim/serial_peer.sv
// Purpose: external serial partner that clocks and exchanges bytes
// Assumes: clock pin idles high; data moves on falling, sampled on rising
// Notes:   sdi flips after a frame so a released line never looks valid
module serial_peer (
	input  wire logic msbFirst,
	input  wire logic sdo,
	input  wire logic sclkWire,
	output logic      sclkDrv,
	output logic      sdi
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] txByte;
	logic [7:0] rxByte;
	int         bitIdx;
	initial
	begin
		sclkDrv = 1'b1;
		sdi = 1'b1;
		txByte = 8'h00;
		rxByte = 8'h00;
		bitIdx = 0;
	end
	task automatic load(input logic [7:0] b);
		txByte = b;
		bitIdx = 0;
	endtask
	// clock stands still high outside frames, 200 ns period within one
	task automatic pulses(input int n);
		repeat (n)
		begin
			#100 sclkDrv = 1'b0;
			#100 sclkDrv = 1'b1;
		end
		#100 sdi = ~sdi;
	endtask
	always @(negedge sclkWire)
		sdi <= msbFirst ? txByte[7 - bitIdx] : txByte[bitIdx];
	always @(posedge sclkWire)
	begin
		rxByte <= msbFirst ? {rxByte[6:0], sdo} : {sdo, rxByte[7:1]};
		bitIdx <= (bitIdx + 1) % 8;
	end
endmodule

// ===== sim/sync_serial_txrx_stop_errors_tb.sv
// Purpose: register-level tests of stop and error handling
// Assumes: classic Wishbone master, external clock from serial_peer
// Notes:   short generated clock half period keeps the run brief
module sync_serial_txrx_stop_errors_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk;
	logic        reset;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [4:0]  adr;
	logic [3:0]  sel;
	logic [31:0] datW;
	logic [31:0] datR;
	logic        ack;
	logic        sclkOut;
	logic        sclkOe_n;
	logic        sclkDrv;
	logic        sclkWire;
	logic        sdi;
	logic        sdo;
	logic        irq;
	logic        msbFirst;
	int          fails;
	int          checks;
	int          irqCount;
	int          irqMark;
	assign sclkWire = (sclkOe_n === 1'b0) ? sclkOut : sclkDrv;
	sync_serial_txrx #(.HALF_CYCLES(4)) u_dut (.mclk(mclk), .reset(reset), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR),
		.ack_o(ack), .sclkIn(sclkWire), .sclkOut(sclkOut), .sclkOe_n(sclkOe_n),
		.sdiIn(sdi), .sdo(sdo), .serialIrqRequest(irq));
	serial_peer peer (.msbFirst(msbFirst), .sdo(sdo), .sclkWire(sclkWire),
		.sclkDrv(sclkDrv), .sdi(sdi));
	initial
		mclk = 1'b0;
	always #12.5 mclk = ~mclk;
	always @(posedge mclk)
		if (irq === 1'b1)
			irqCount++;
	task automatic end_of_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// holds the request until ack is sampled high, then releases for a cycle
	task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datW <= {24'h0, d};
		do
		begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		q = datR;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		chk("ack", 32'h1, {31'h0, n < 40});
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input string nm, input logic [4:0] a, input logic [7:0] e);
		logic [31:0] q;
		wb(1'b0, a, 8'h00, q);
		chk(nm, {24'h0, e}, q);
	endtask
	// one external byte, status read mid byte, then a control write
	task automatic xfer(input logic [7:0] midStat, input logic [7:0] ctl);
		fork
			peer.pulses(8);
			begin
				#350;
				rd("status mid byte", sio_pkg::STAT_ADDR, midStat);
				wr(sio_pkg::CTRL_ADDR, ctl);
			end
		join
	endtask
	initial
	begin
		#300000;
		fails++;
		end_of_test();
	end
	initial
	begin
		reset = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 5'h00;
		sel = 4'h1;
		datW = 32'h00000000;
		msbFirst = 1'b1;
		{fails, checks, irqCount} = {32'd0, 32'd0, 32'd0};
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		rd("status reset", sio_pkg::STAT_ADDR, 8'h04);
		wr(sio_pkg::STAT_ADDR, 8'hff);
		rd("status read only", sio_pkg::STAT_ADDR, 8'h04);
		rd("unmapped", 5'h10, 8'h00);
		wr(sio_pkg::TXBUF_ADDR, 8'ha5);
		sel <= 4'h0;
		wr(sio_pkg::TXBUF_ADDR, 8'h77);
		sel <= 4'h1;
		rd("tx kept", sio_pkg::TXBUF_ADDR, 8'ha5);
		rd("tx written", sio_pkg::STAT_ADDR, 8'h00);
		peer.load(8'h3c);
		wr(sio_pkg::CTRL_ADDR, 8'h39);
		xfer(8'h07, 8'h38);
		rd("status stopped", sio_pkg::STAT_ADDR, 8'h0c);
		chk("sdo idle", 32'h1, {31'h0, sdo});
		chk("peer msb", 32'ha5, {24'h0, peer.rxByte});
		rd("rx msb", sio_pkg::RXBUF_ADDR, 8'h3c);
		rd("rx read", sio_pkg::STAT_ADDR, 8'h04);
		chk("irq byte", 32'h1, 32'(irqCount));
		msbFirst <= 1'b0;
		peer.load(8'h5a);
		wr(sio_pkg::TXBUF_ADDR, 8'h96);
		wr(sio_pkg::CTRL_ADDR, 8'h09);
		@(negedge mclk);
		chk("clock driven", 32'h0, {31'h0, sclkOe_n});
		repeat (80) @(posedge mclk);
		wr(sio_pkg::CTRL_ADDR, 8'h08);
		repeat (20) @(posedge mclk);
		rd("rx lsb", sio_pkg::RXBUF_ADDR, 8'h5a);
		chk("peer lsb", 32'h96, {24'h0, peer.rxByte});
		rd("internal done", sio_pkg::STAT_ADDR, 8'h04);
		msbFirst <= 1'b1;
		peer.load(8'hc3);
		wr(sio_pkg::CTRL_ADDR, 8'h39);
		xfer(8'h17, 8'h38);
		rd("underrun", sio_pkg::STAT_ADDR, 8'h1c);
		chk("sdo high", 32'hff, {24'h0, peer.rxByte});
		chk("irq underrun", 32'h3, 32'(irqCount));
		rd("rx underrun", sio_pkg::RXBUF_ADDR, 8'hc3);
		wr(sio_pkg::CTRL_ADDR, 8'h3b);
		rd("ctrl stop", sio_pkg::CTRL_ADDR, 8'h38);
		rd("status stop", sio_pkg::STAT_ADDR, 8'h04);
		rd("rx stop", sio_pkg::RXBUF_ADDR, 8'h00);
		rd("tx stop", sio_pkg::TXBUF_ADDR, 8'h00);
		wr(sio_pkg::TXBUF_ADDR, 8'h11);
		peer.load(8'h81);
		wr(sio_pkg::CTRL_ADDR, 8'h39);
		xfer(8'h07, 8'h39);
		wr(sio_pkg::TXBUF_ADDR, 8'h22);
		peer.load(8'h7e);
		xfer(8'h0f, 8'h39);
		chk("peer second", 32'h22, {24'h0, peer.rxByte});
		irqMark = irqCount;
		peer.load(8'h55);
		peer.pulses(8);
		chk("irq overrun", 32'(irqMark), 32'(irqCount));
		wr(sio_pkg::CTRL_ADDR, 8'h38);
		rd("overrun", sio_pkg::STAT_ADDR, 8'h3c);
		rd("rx first", sio_pkg::RXBUF_ADDR, 8'h81);
		rd("overrun kept", sio_pkg::STAT_ADDR, 8'h3c);
		rd("rx second", sio_pkg::RXBUF_ADDR, 8'h7e);
		rd("overrun clear", sio_pkg::STAT_ADDR, 8'h14);
		end_of_test();
	end
endmodule
